// [rtl/pse_defines.svh]
// Constants of the power sequencing engine: offsets, reset values, timing.
// Assumes a 100 MHz core clock and a 32-bit classic Wishbone register bus.
`ifndef PSE_DEFINES_SVH
`define PSE_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PSE_OFS_CTRL     8'h00
`define PSE_OFS_STATUS   8'h04
`define PSE_OFS_SRC      8'h08
`define PSE_OFS_MODE     8'h0c
`define PSE_OFS_HOSTOUT  8'h10
`define PSE_OFS_TBLIDX   8'h14
`define PSE_OFS_TBLW0    8'h18
`define PSE_OFS_TBLW1    8'h1c
`define PSE_OFS_TBLW2    8'h20
`define PSE_OFS_TBLW3    8'h24
`define PSE_OFS_TBLW4    8'h28

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define PSE_CTRL_JUMP_BIT  0
`define PSE_RST_SRC        16'h0000
`define PSE_RST_MODE       24'h000000
`define PSE_RST_HOSTOUT    8'h00
`define PSE_LAST_STATE     6'h3e

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PSE_CLK_MHZ        100
`define PSE_OSC_HZ         100000
`define PSE_DIV_HALF       (`PSE_CLK_MHZ * 1000000 / `PSE_OSC_HZ / 2)
`define PSE_TICK_US        10
`define PSE_START_DLY_NS   500000
`define PSE_START_DLY_CYC  (`PSE_START_DLY_NS * `PSE_CLK_MHZ / 1000)
`define PSE_XFER_MAX_US    20
`define PSE_XFER_MAX_CYC   (`PSE_XFER_MAX_US * `PSE_CLK_MHZ)
`define PSE_DLY_MAX_MS     400
`define PSE_DLY_MAX_TICKS  (`PSE_DLY_MAX_MS * 1000 / `PSE_TICK_US)

`endif

// [rtl/pse_pkg.sv]
// Types of the power sequencing engine.
// Assumes eight output pins, nine condition inputs and 63 states.
package pse_pkg;

	// Sequencer phase, one-hot
	typedef enum logic [3:0] {
		SQ_WAIT_CFG  = 4'b0001,
		SQ_START_DLY = 4'b0010,
		SQ_FETCH     = 4'b0100,
		SQ_RUN       = 4'b1000
	} pse_seq_t;

	// Pin data source
	typedef enum logic [1:0] {
		SRC_SEQ  = 2'h0,
		SRC_HOST = 2'h1,
		SRC_CLK  = 2'h2
	} pse_src_t;

	// Pin drive mode
	typedef enum logic [2:0] {
		DRV_OD     = 3'h0,
		DRV_WEAKPU = 3'h1,
		DRV_PP     = 3'h2,
		DRV_STRPD  = 3'h3,
		DRV_CP     = 3'h4
	} pse_drv_t;

	// One state definition
	typedef struct packed {
		logic [7:0]  out;
		logic [5:0]  seq_nxt;
		logic [8:0]  seq_msk;
		logic [8:0]  seq_val;
		logic [5:0]  to_nxt;
		logic [8:0]  to_msk;
		logic [8:0]  to_val;
		logic [5:0]  mon_nxt;
		logic [8:0]  mon_msk;
		logic [8:0]  mon_val;
		logic [15:0] seq_dly;
		logic [15:0] to_dly;
	} pse_entry_t;

endpackage

// [rtl/pse_top.sv]
// Power sequencing engine: state table, exit routes, pin source and drive.
// Assumes a classic Wishbone master and fault/warning inputs from pins.
//
// Function
// RULE1 - Each pin picks sequencer, host or clock
// RULE2 - Internal 100 kHz clock routable to pins
// RULE3 - Host-written level appears on host pins
// RULE4 - State table holds 63 definitions
// RULE5 - Every state watches all eight fault detectors
// RULE6 - Any state may follow any state
// RULE7 - Sequence, monitor and timeout exits per state
// RULE8 - Two per-state delays, 0-400 ms, reloaded
// RULE9 - State fixes sequencer pin levels while active
// RULE10 - Transition with fetch under 20 us
// RULE11 - Warnings ORed into all exit routes
// RULE12 - Warning from limit or secondary monitor
// RULE13 - Host jump forces programmed next state
// RULE14 - Jump feeds sequence and timeout exits; the code feeds it to the sequence exit only
// RULE15 - Weak pull-low until configuration loaded
// RULE16 - Drive modes; charge pump pins 1-6
// RULE17 - Timeout fires if condition unmet after delay
// RULE18 - Monitor fires on any selected deviation
// RULE19 - First state loads 0.5 ms after config
// RULE20 - Monitor exit has no delay
// RULE21 - Priority monitor, then timeout, then sequence
// RULE22 - Delay timers restart on each entry
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/100ps

`include "pse_defines.svh"

module pse_top
	import pse_pkg::*;
#(
	parameter int START_DLY_CYC = `PSE_START_DLY_CYC  // Delay before state 0
) (
	input  wire logic        ref_clk_i,             // Core clock, 100 MHz
	input  wire logic        rst_i,                 // Async reset, high
	input  wire logic        wb_cyc_i,              // Wishbone cycle
	input  wire logic        wb_stb_i,              // Wishbone strobe
	input  wire logic        wb_we_i,               // Wishbone write
	input  wire logic [7:0]  wb_adr_i,              // Wishbone byte address
	input  wire logic [3:0]  wb_sel_i,              // Wishbone byte lanes
	input  wire logic [31:0] wb_dat_i,              // Wishbone write data
	output logic      [31:0] wb_dat_o,              // Wishbone read data
	output logic             wb_ack_o,              // Wishbone ack
	input  wire logic [7:0]  supply_fault_detector_i, // Detector ok levels
	input  wire logic        adc_warn_i,            // Conversion limit hit
	input  wire logic [3:0]  sec_warn_i,            // Secondary monitors
	input  wire logic        cfg_done_i,            // Config load finished
	input  wire logic        supply_1v_i,           // Some supply above 1 V
	output logic      [7:0]  ctrl_output_pin_o,     // Pin level
	output logic      [7:0]  ctrl_output_pin_oe_o,  // Pin driven
	output logic      [7:0]  pin_weak_pu_o,         // Weak pull-up on
	output logic      [7:0]  pin_weak_pd_o,         // Weak pull-down on
	output logic      [7:0]  pin_strong_o,          // Strong pull-down mode
	output logic      [7:0]  pin_cp_en_o,           // Charge pump drive
	output logic      [5:0]  state_o,               // Current state
	output logic             warning_o              // Combined warning
);

	// ------------------------------------------------------------------------
	// State record
	// ------------------------------------------------------------------------
	localparam int NSYNC = 15;                      // Synchronised inputs
	localparam int DIVH  = `PSE_DIV_HALF;            // Half period of osc
	localparam int DMAX  = `PSE_DLY_MAX_TICKS;       // Largest delay

	typedef struct packed {
		pse_seq_t                seq_st;   // Sequencer phase
		logic [5:0]              cur;      // Current state index
		logic [7:0]              out_lvl;  // Levels of current state
		logic [7:0]              pin_lvl;  // Registered pin levels
		logic [7:0]              pin_oe;   // Registered enables
		logic [7:0]              pin_wpu;  // Weak pull-up
		logic [7:0]              pin_wpd;  // Weak pull-down
		logic [7:0]              pin_str;  // Strong pull-down
		logic [7:0]              pin_cp;   // Charge pump
		logic [NSYNC-1:0]        sync1;    // First sync stage
		logic [NSYNC-1:0]        sync2;    // Second sync stage
		logic [NSYNC-1:0]        sync3;    // Third sync stage
		logic [NSYNC-1:0]        filt;     // Agreed input levels
		logic [15:0]             start_cnt;// Start delay counter
		logic [9:0]              div;      // Oscillator divider
		logic                    clk100;   // 100 kHz clock
		logic                    tick;     // One pulse per period
		logic [15:0]             seq_tmr;  // Sequence delay timer
		logic [15:0]             to_tmr;   // Timeout delay timer
		logic                    jump_pend;// Host jump waiting
		logic [15:0]             src;      // Source per pin
		logic [23:0]             mode;     // Drive mode per pin
		logic [7:0]              host_out; // Host-written levels
		logic [5:0]              tbl_idx;  // Table window index
		pse_entry_t [62:0]       tbl;      // State definitions
		logic                    ack;      // Bus ack
		logic [31:0]             dat;      // Bus read data
	} pse_state_t;

	pse_state_t s;                                   // Current state
	pse_state_t next_s;                              // Next state

	// Merge write data into an old word by byte lane
	function automatic logic [31:0] pse_merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Clamp a delay field to the largest programmable delay
	function automatic logic [15:0] pse_clamp(input logic [15:0] d);
		return (d > 16'(DMAX)) ? 16'(DMAX) : d;
	endfunction

	// ------------------------------------------------------------------------
	// Combinational helpers
	// ------------------------------------------------------------------------
	logic [NSYNC-1:0] agree;                         // Stages 2 and 3 match
	logic [8:0]       cond;                          // Warning and detectors
	logic             warn;                          // Combined warning
	logic             cfg_ok;                        // Config loaded
	logic             v1_ok;                         // Supply above 1 V
	pse_entry_t       ce;                            // Entry of current state
	logic             seq_hit;                       // Sequence route fires
	logic             to_hit;                        // Timeout route fires
	logic             mon_hit;                       // Monitor route fires
	logic             fire;                          // A route is taken
	logic [5:0]       nxt;                           // Chosen next state

	// Input qualification and route evaluation
	always_comb begin
		agree   = ~(s.sync2 ^ s.sync3);
		warn    = |s.filt[12:8];                         // RULE11 RULE12
		cfg_ok  = s.filt[13];
		v1_ok   = s.filt[14];
		cond    = {warn, s.filt[7:0]};                   // RULE5
		ce      = s.tbl[s.cur];
		mon_hit = |((cond ^ ce.mon_val) & ce.mon_msk);   // RULE18 RULE20
		to_hit  = (ce.to_msk != 9'h000) && (s.to_tmr >= ce.to_dly)
			&& (((cond ^ ce.to_val) & ce.to_msk) != 9'h000); // RULE17
		seq_hit = ((ce.seq_msk != 9'h000) && (s.seq_tmr >= ce.seq_dly)
			&& (((cond ^ ce.seq_val) & ce.seq_msk) == 9'h000))
			|| s.jump_pend;                             // RULE13 RULE14
		// Monitor first, then timeout, then sequence
		if (mon_hit) begin                              // RULE21
			nxt = ce.mon_nxt;
		end else if (to_hit) begin
			nxt = ce.to_nxt;
		end else begin
			nxt = ce.seq_nxt;
		end
		// Any index may follow; index 63 does not exist and is ignored
		fire = (mon_hit || to_hit || seq_hit)
			&& (nxt <= `PSE_LAST_STATE);                 // RULE6 RULE7
	end

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------
	always_comb begin
		logic [31:0] wv;
		logic        wr_jump;
		logic        wr;
		pse_entry_t  te;
		logic [1:0]  sel;
		logic        d;
		wv      = 32'h00000000;
		wr      = 1'b0;
		wr_jump = 1'b0;
		te      = s.tbl[s.tbl_idx];
		sel     = 2'h0;
		d       = 1'b0;
		next_s  = s;

		// Three-stage synchroniser, change counts when stages 2 and 3 agree
		next_s.sync1 = {supply_1v_i, cfg_done_i, sec_warn_i, adc_warn_i,
			supply_fault_detector_i};
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		next_s.filt  = (s.filt & ~agree) | (s.sync2 & agree);

		// 100 kHz oscillator and its period tick
		next_s.tick = 1'b0;
		if (s.div == 10'(DIVH - 1)) begin                // RULE2
			next_s.div    = 10'h000;
			next_s.clk100 = ~s.clk100;
			next_s.tick   = s.clk100;
		end else begin
			next_s.div = s.div + 10'h001;
		end

		// Wishbone slave: one wait state, unmapped reads as zero
		next_s.ack = 1'b0;
		wr         = wb_cyc_i && wb_stb_i && !s.ack && wb_we_i;
		if (wb_cyc_i && wb_stb_i && !s.ack) begin
			next_s.ack = 1'b1;
			next_s.dat = 32'h00000000;
			if (wb_adr_i == `PSE_OFS_CTRL) begin
				// Writing one to the jump bit requests a jump
				wr_jump = wr && wb_sel_i[0]
					&& wb_dat_i[`PSE_CTRL_JUMP_BIT];
				next_s.dat = {30'h0, cfg_ok, s.jump_pend};
			end else if (wb_adr_i == `PSE_OFS_STATUS) begin
				next_s.dat = {8'h00, s.filt[7:0], 3'h0, warn,
					s.seq_st, 2'h0, s.cur};
			end else if (wb_adr_i == `PSE_OFS_SRC) begin
				wv = pse_merge({16'h0, s.src}, wb_dat_i, wb_sel_i);
				if (wr) begin
					next_s.src = wv[15:0];
				end
				next_s.dat = {16'h0, s.src};
			end else if (wb_adr_i == `PSE_OFS_MODE) begin
				wv = pse_merge({8'h0, s.mode}, wb_dat_i, wb_sel_i);
				if (wr) begin
					next_s.mode = wv[23:0];
				end
				next_s.dat = {8'h0, s.mode};
			end else if (wb_adr_i == `PSE_OFS_HOSTOUT) begin
				if (wr && wb_sel_i[0]) begin
					next_s.host_out = wb_dat_i[7:0];
				end
				next_s.dat = {24'h0, s.host_out};
			end else if (wb_adr_i == `PSE_OFS_TBLIDX) begin
				// Indices beyond the last state are pinned to it
				if (wr && wb_sel_i[0]) begin
					next_s.tbl_idx = (wb_dat_i[5:0] > `PSE_LAST_STATE)
						? `PSE_LAST_STATE : wb_dat_i[5:0];
				end
				next_s.dat = {26'h0, s.tbl_idx};
			end else if (wb_adr_i == `PSE_OFS_TBLW0) begin
				wv = pse_merge({2'h0, te.mon_nxt, 2'h0, te.to_nxt, 2'h0,
					te.seq_nxt, te.out}, wb_dat_i, wb_sel_i);
				te.out     = wv[7:0];
				te.seq_nxt = wv[13:8];
				te.to_nxt  = wv[21:16];
				te.mon_nxt = wv[29:24];
				next_s.dat = {2'h0, s.tbl[s.tbl_idx].mon_nxt, 2'h0,
					s.tbl[s.tbl_idx].to_nxt, 2'h0,
					s.tbl[s.tbl_idx].seq_nxt, s.tbl[s.tbl_idx].out};
			end else if (wb_adr_i == `PSE_OFS_TBLW1) begin
				wv = pse_merge({7'h0, te.seq_val, 7'h0, te.seq_msk},
					wb_dat_i, wb_sel_i);
				te.seq_msk = wv[8:0];
				te.seq_val = wv[24:16];
				next_s.dat = {7'h0, s.tbl[s.tbl_idx].seq_val, 7'h0,
					s.tbl[s.tbl_idx].seq_msk};
			end else if (wb_adr_i == `PSE_OFS_TBLW2) begin
				wv = pse_merge({7'h0, te.to_val, 7'h0, te.to_msk},
					wb_dat_i, wb_sel_i);
				te.to_msk  = wv[8:0];
				te.to_val  = wv[24:16];
				next_s.dat = {7'h0, s.tbl[s.tbl_idx].to_val, 7'h0,
					s.tbl[s.tbl_idx].to_msk};
			end else if (wb_adr_i == `PSE_OFS_TBLW3) begin
				wv = pse_merge({7'h0, te.mon_val, 7'h0, te.mon_msk},
					wb_dat_i, wb_sel_i);
				te.mon_msk = wv[8:0];
				te.mon_val = wv[24:16];
				next_s.dat = {7'h0, s.tbl[s.tbl_idx].mon_val, 7'h0,
					s.tbl[s.tbl_idx].mon_msk};
			end else if (wb_adr_i == `PSE_OFS_TBLW4) begin
				wv = pse_merge({te.to_dly, te.seq_dly}, wb_dat_i, wb_sel_i);
				te.seq_dly = pse_clamp(wv[15:0]);       // RULE8
				te.to_dly  = pse_clamp(wv[31:16]);
				next_s.dat = {s.tbl[s.tbl_idx].to_dly,
					s.tbl[s.tbl_idx].seq_dly};
			end
			// Table window writes land in the indexed entry
			if (wr && (wb_adr_i >= `PSE_OFS_TBLW0)
				&& (wb_adr_i <= `PSE_OFS_TBLW4)) begin
				next_s.tbl[s.tbl_idx] = te;             // RULE4
			end
		end

		// Jump request: a new write wins over consumption
		next_s.jump_pend = (s.jump_pend && (s.seq_st != SQ_RUN))
			|| wr_jump;

		// Sequencer phases
		case (s.seq_st)
			SQ_WAIT_CFG: begin
				// Hold until the configuration has loaded
				if (cfg_ok) begin
					next_s.seq_st    = SQ_START_DLY;
					next_s.start_cnt = 16'h0000;
				end
			end
			SQ_START_DLY: begin
				// Settle before the first state is fetched
				if (s.start_cnt >= 16'(START_DLY_CYC - 1)) begin // RULE19
					next_s.seq_st = SQ_FETCH;
					next_s.cur    = 6'h00;
				end else begin
					next_s.start_cnt = s.start_cnt + 16'h0001;
				end
			end
			SQ_FETCH: begin
				// Load the state definition and restart both timers
				next_s.out_lvl = ce.out;                // RULE9
				next_s.seq_tmr = 16'h0000;              // RULE22 RULE8
				next_s.to_tmr  = 16'h0000;
				next_s.seq_st  = SQ_RUN;                // RULE10
			end
			SQ_RUN: begin
				// Timers count oscillator periods and saturate
				if (s.tick && (s.seq_tmr != 16'hffff)) begin
					next_s.seq_tmr = s.seq_tmr + 16'h0001;
				end
				if (s.tick && (s.to_tmr != 16'hffff)) begin
					next_s.to_tmr = s.to_tmr + 16'h0001;
				end
				if (fire) begin
					next_s.cur    = nxt;
					next_s.seq_st = SQ_FETCH;
				end
			end
			default: begin
				next_s.seq_st = SQ_WAIT_CFG;
			end
		endcase

		// Pin source select and drive mode
		for (int i = 0; i < 8; i++) begin
			sel = s.src[2*i +: 2];
			if (sel == SRC_HOST) begin                  // RULE3
				d = s.host_out[i];
			end else if (sel == SRC_CLK) begin          // RULE2
				d = s.clk100;
			end else begin                              // RULE1
				d = s.out_lvl[i];
			end
			next_s.pin_lvl[i] = d;
			next_s.pin_oe[i]  = !d;
			next_s.pin_wpu[i] = 1'b0;
			next_s.pin_wpd[i] = 1'b0;
			next_s.pin_str[i] = 1'b0;
			next_s.pin_cp[i]  = 1'b0;
			case (s.mode[3*i +: 3])
				DRV_WEAKPU: next_s.pin_wpu[i] = 1'b1;   // RULE16
				DRV_PP:     next_s.pin_oe[i]  = 1'b1;
				DRV_STRPD:  next_s.pin_str[i] = 1'b1;
				DRV_CP: begin
					// Only the first six pins own a charge pump
					next_s.pin_cp[i] = (i < 6) && d;
				end
				default: next_s.pin_oe[i] = !d;
			endcase
			// Before configuration only the weak pull-down acts
			if (s.seq_st == SQ_WAIT_CFG) begin          // RULE15
				next_s.pin_lvl[i] = 1'b0;
				next_s.pin_oe[i]  = 1'b0;
				next_s.pin_wpu[i] = 1'b0;
				next_s.pin_str[i] = 1'b0;
				next_s.pin_cp[i]  = 1'b0;
				next_s.pin_wpd[i] = v1_ok;
			end
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s          <= '0;
			s.seq_st   <= SQ_WAIT_CFG;
			s.src      <= `PSE_RST_SRC;
			s.mode     <= `PSE_RST_MODE;
			s.host_out <= `PSE_RST_HOSTOUT;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state record
	assign wb_dat_o             = s.dat;
	assign wb_ack_o             = s.ack;
	assign ctrl_output_pin_o    = s.pin_lvl & s.pin_oe;
	assign ctrl_output_pin_oe_o = s.pin_oe;
	assign pin_weak_pu_o        = s.pin_wpu;
	assign pin_weak_pd_o        = s.pin_wpd;
	assign pin_strong_o         = s.pin_str;
	assign pin_cp_en_o          = s.pin_cp;
	assign state_o              = s.cur;
	assign warning_o            = warn;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence fetch_then_run_s;
		(s.seq_st == SQ_FETCH) ##1 (s.seq_st == SQ_RUN);
	endsequence

	host_level_a: assert property (                  // RULE3
		(s.seq_st != SQ_WAIT_CFG) && (s.src[5:4] == SRC_HOST)
		&& (s.mode[8:6] == DRV_PP) |=> (s.pin_lvl[2] == $past(s.host_out[2])))
		else $error("host level not on pin 2");
	osc_period_a: assert property (                  // RULE2
		(s.clk100 != $past(s.clk100)) |-> ($past(s.div) == 10'(DIVH - 1)))
		else $error("oscillator toggled off its count");
	route_prio_a: assert property (                  // RULE21
		(s.seq_st == SQ_RUN) && mon_hit && (ce.mon_nxt <= 6'h3e)
		|=> (s.cur == $past(ce.mon_nxt)))
		else $error("monitor route not taken first");
	seq_delay_a: assert property (                   // RULE8
		(s.seq_st == SQ_RUN) && fire && !mon_hit && !to_hit && !s.jump_pend
		|-> (s.seq_tmr >= ce.seq_dly))
		else $error("sequence route before its delay");
	fetch_time_a: assert property (                  // RULE10
		(s.seq_st == SQ_RUN) && fire |=> fetch_then_run_s)
		else $error("state transition too slow");
	out_hold_a: assert property (                    // RULE9
		(s.seq_st == SQ_RUN) && $past(s.seq_st == SQ_RUN)
		|-> $stable(s.out_lvl))
		else $error("state levels moved within a state");
	undriven_a: assert property (                    // RULE15
		(s.seq_st == SQ_WAIT_CFG) |=> (s.pin_oe == 8'h00))
		else $error("pin driven before configuration");
	tmr_restart_a: assert property (                 // RULE22
		(s.seq_st == SQ_FETCH) |=> (s.seq_tmr == 16'h0000)
		&& (s.to_tmr == 16'h0000))
		else $error("delay timers not restarted");
	cp_pins_a: assert property (                     // RULE16
		s.pin_cp[7:6] == 2'h0)
		else $error("charge pump on pin 7 or 8");
	start_dly_a: assert property (                   // RULE19
		(s.seq_st == SQ_START_DLY) && (s.start_cnt == 16'h0000)
		|-> (s.seq_st == SQ_START_DLY) [*2])
		else $error("first state fetched too early");

endmodule

// [tb/pse_rail_model.sv]
// Board regulator model: rail n comes good a few cycles after pin n enables.
// Assumes pin n drives the rail watched by detector n.
`timescale 1ns/100ps
module pse_rail_model (
	input  wire logic       clk_i,   // Core clock
	input  wire logic [7:0] en_i,    // Enable pin levels
	input  wire logic [7:0] oe_i,    // Pin driven
	input  wire logic [7:0] fault_i, // Rails forced bad
	output logic      [7:0] ok_o     // Rail good levels
);
	logic [7:0] r1 = 8'h00; // Soft-start stage 1
	logic [7:0] r2 = 8'h00; // Soft-start stage 2
	// Rail ramps only while its pin is driven high
	always @(posedge clk_i) begin
		r1 <= en_i & oe_i;
		r2 <= r1;
	end
	assign ok_o = r2 & ~fault_i; // Injected faults pull the rail out
endmodule

// [tb/power_sequencing_engine_test.sv]
// Bench: state table, exit routes and pin sources against a small model.
// Assumes the rail model on the pins and a classic Wishbone master here.
`timescale 1ns/100ps
`include "pse_defines.svh"
module power_sequencing_engine_test;
	logic        ref_clk_i = 1'b0; // Core clock
	logic        rst_i = 1'b1;     // Reset
	logic        cyc = 1'b0;       // Bus request
	logic        we = 1'b0;        // Bus write
	logic [7:0]  adr = 8'h00;      // Bus address
	logic [31:0] wdat = 32'h0;     // Bus write data
	logic [31:0] rdat, dat_o, r;   // Read data, random value
	logic        ack, warn, p3;    // Ack, warning, last clock pin
	logic        cfg = 1'b0;       // Config loaded
	logic        adc = 1'b0;       // Conversion warning
	logic [3:0]  sec = 4'h0;       // Secondary warnings
	logic [7:0]  ok, pin, oe, wpd; // Rails, pins
	logic [7:0]  wpu, str, cp;     // Pull-up, strong, pump
	logic        v1 = 1'b0;        // Some supply at 1 V
	logic [7:0]  flt = 8'h00;      // Injected rail faults
	logic [5:0]  st;               // State index
	int          errors = 0;       // Mismatches
	int          checks = 0;       // Comparisons
	int          n;                // Cycle counter
	int          exp_out [int];    // Model: sequencer levels per state
	int          path [$] = {1, 3, 5, 62, 20}; // Model: visit order
	// Index, then W0..W4 of each table entry
	int ent [6][6] = '{
		'{32'h0, 32'h101, 32'h10001, 32'h0, 32'h0, 32'h0},
		'{32'h1, 32'h30003, 32'h0, 32'h800080, 32'h0, 32'h20000},
		'{32'h3, 32'h5000007, 32'h0, 32'h0, 32'h10001, 32'h0},
		'{32'h5, 32'h3e00, 32'h0, 32'h0, 32'h0, 32'h0},
		'{32'h3e, 32'h14000a80, 32'h1000100, 32'h0, 32'h100, 32'h0},
		'{32'h14, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0}};

	always #5 ref_clk_i = ~ref_clk_i;

	pse_top #(.START_DLY_CYC(20)) dut_u (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.supply_fault_detector_i(ok), .adc_warn_i(adc), .sec_warn_i(sec),
		.cfg_done_i(cfg), .supply_1v_i(v1), .ctrl_output_pin_o(pin),
		.ctrl_output_pin_oe_o(oe), .pin_weak_pu_o(wpu), .pin_weak_pd_o(wpd),
		.pin_strong_o(str), .pin_cp_en_o(cp), .state_o(st), .warning_o(warn));

	pse_rail_model rail_u (.clk_i(ref_clk_i), .en_i(pin), .oe_i(oe),
		.fault_i(flt), .ok_o(ok));

	// Verdict and end of run
	task automatic report_and_stop();
		if (errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Compare one value
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	// One classic cycle; held until ack is sampled
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge ref_clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		rdat = dat_o;
		cyc <= 1'b0;
		if (k >= 50) begin
			chk("ack", 32'h0, 32'h1);
			report_and_stop();
		end
	endtask

	// Bounded wait for a state
	task automatic wait_st(input int s, input int lim);
		n = 0;
		while (st !== s[5:0] && n < lim) begin
			@(posedge ref_clk_i);
			n++;
		end
		chk("state", {26'h0, st}, s);
		if (n >= lim)
			report_and_stop();
	endtask

	// Watchdog against a hang
	initial begin
		#1000000;
		chk("watchdog", 32'h0, 32'h1);
		report_and_stop();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h0ac0));
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		chk("pd before 1v", wpd, 8'h00);
		v1 <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		chk("weak_pd", wpd, 8'hff);
		chk("oe idle", oe, 8'h00);
		wb(`PSE_OFS_SRC, 1'b1, 32'h0);
		wb(`PSE_OFS_MODE, 1'b1, 32'h492492);
		wb(8'h3c, 1'b0, 32'h0);
		chk("unmapped", rdat, 32'h0);
		foreach (ent[i]) begin
			wb(`PSE_OFS_TBLIDX, 1'b1, ent[i][0]);
			for (int k = 0; k < 5; k++)
				wb(`PSE_OFS_TBLW0 + 8'(4 * k), 1'b1, ent[i][k + 1]);
			exp_out[ent[i][0]] = ent[i][1] & 32'hff;
		end
		cfg <= 1'b1;
		n = 0;
		while (pin !== 8'h01 && n < 100) begin
			@(posedge ref_clk_i);
			n++;
		end
		chk("start delay", 32'(n >= 20 && n < 40), 32'h1);
		chk("state0 pins", pin, 8'h01);
		foreach (path[i]) begin
			// Event that should move the sequencer on
			case (i)
				2: flt <= 8'h01;
				3: wb(`PSE_OFS_CTRL, 1'b1, 32'h1);
				4: begin
					r = $urandom % 5;
					if (r == 4)
						adc <= 1'b1;
					else
						sec[r[1:0]] <= 1'b1;
				end
				default: ;
			endcase
			wait_st(path[i], 4000);
			if (i == 1)
				chk("timeout", 32'(n > 900 && n < 2100), 32'h1);
			if (i == 2)
				chk("monitor", 32'(n < 10), 32'h1);
			if (i == 4)
				chk("warning", warn, 32'h1);
			repeat (4) @(posedge ref_clk_i);
			chk("pins", pin, exp_out[path[i]]);
		end
		r = $urandom;
		wb(`PSE_OFS_HOSTOUT, 1'b1, {24'h0, r[7:0]});
		wb(`PSE_OFS_SRC, 1'b1, 32'h90);
		repeat (5) @(posedge ref_clk_i);
		chk("host pin", pin[2], r[2]);
		n = 0;
		p3 = pin[3];
		repeat (3000) begin
			@(posedge ref_clk_i);
			if (pin[3] && !p3)
				n++;
			p3 = pin[3];
		end
		chk("clock edges", n, 32'h3);
		// Every pin host-driven high, then weak pull-up, strong pull-down and charge pump modes in turn
		wb(`PSE_OFS_SRC, 1'b1, 32'h5555);
		wb(`PSE_OFS_HOSTOUT, 1'b1, 32'hff);
		wb(`PSE_OFS_MODE, 1'b1, 32'h249249);
		repeat (2) @(posedge ref_clk_i);
		chk("weak pu", wpu, 8'hff);
		wb(`PSE_OFS_MODE, 1'b1, 32'h6db6db);
		repeat (2) @(posedge ref_clk_i);
		chk("strong pd", str, 8'hff);
		wb(`PSE_OFS_MODE, 1'b1, 32'h924924);
		repeat (2) @(posedge ref_clk_i);
		chk("charge pump", cp, 8'h3f);
		report_and_stop();
	end
endmodule
